/* File: logic/eabf_datapath.v */
// Holds the execution datapath: address generation, bit fields, BCD and bounds.
// Assumes the decoder holds the operands steady while start is high for one cycle.
`timescale 1ns/1ps
`include "eabf_defs.vh"

module eabf_datapath #(
  parameter W = 32
) (
  input  wire            clk,
  input  wire            arst_n,
  input  wire            start,
  input  wire [4:0]      op_code,
  input  wire [4:0]      ea_mode,
  input  wire [1:0]      op_size,
  input  wire [2:0]      data_reg_select,
  input  wire [2:0]      addr_reg_select,
  input  wire [3:0]      index_reg_select,
  input  wire            index_long,
  input  wire [1:0]      index_scale,
  input  wire            index_suppress,
  input  wire [15:0]     short_disp,
  input  wire            short_disp_is8,
  input  wire [31:0]     base_displacement,
  input  wire            base_disp_long,
  input  wire [31:0]     outer_displacement,
  input  wire            outer_disp_long,
  input  wire [31:0]     ext_word,
  input  wire [31:0]     pc_value,
  input  wire [255:0]    data_regs,
  input  wire [255:0]    addr_regs,
  input  wire [63:0]     field_window,
  input  wire [5:0]      field_offset,
  input  wire [5:0]      field_width,
  input  wire [31:0]     operand_a,
  input  wire [31:0]     operand_b,
  input  wire [63:0]     quad_a,
  input  wire [63:0]     quad_b,
  input  wire [15:0]     bcd_adjust,
  input  wire            bound_signed,
  input  wire            mem_ack,
  input  wire [31:0]     mem_rdata,
  output reg             mem_req,
  output reg  [31:0]     mem_addr,
  output reg             done,
  output reg  [31:0]     ea_out,
  output reg             ea_is_reg,
  output reg             areg_we,
  output reg  [31:0]     areg_new,
  output reg  [31:0]     result,
  output reg  [63:0]     result_quad,
  output reg  [63:0]     window_out,
  output reg  [3:0]      ccr_out,
  output reg             trap
);

////////////////////////////////////////////////////////////////////////////////
// Register selection and index scaling.

  localparam S_IDLE  = 2'd0;
  localparam S_FETCH = 2'd1;
  localparam S_DONE  = 2'd2;

  reg  [1:0]  state;
  reg  [31:0] areg_val;
  reg  [31:0] dreg_val;
  reg  [31:0] idx_raw;
  reg  [31:0] idx_ext;
  reg  [31:0] idx_scaled;
  reg  [31:0] d_short;
  reg  [31:0] base_disp_ext;
  reg  [31:0] outer_disp_ext;
  reg  [31:0] size_step;
  reg  [31:0] base_val;
  reg  [31:0] next_ea;
  reg  [31:0] pre_sum;
  reg         is_mem;
  reg         is_pre;
  reg  [31:0] saved_post;

  always @* begin
    areg_val = addr_regs[addr_reg_select*32 +: 32];
    dreg_val = data_regs[data_reg_select*32 +: 32];
    idx_raw  = index_reg_select[3] ? addr_regs[index_reg_select[2:0]*32 +: 32]
                                   : data_regs[index_reg_select[2:0]*32 +: 32];
    idx_ext  = index_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};
    idx_scaled = index_suppress ? 32'h0000_0000 : (idx_ext << index_scale);
    d_short  = short_disp_is8 ? {{24{short_disp[7]}}, short_disp[7:0]}
                              : {{16{short_disp[15]}}, short_disp};
    base_disp_ext  = base_disp_long ? base_displacement
                                    : {{16{base_displacement[15]}}, base_displacement[15:0]};
    outer_disp_ext = outer_disp_long ? outer_displacement
                               : {{16{outer_displacement[15]}}, outer_displacement[15:0]};
    case (op_size)
      `EABF_SZ_BYTE: size_step = (addr_reg_select == 3'd7) ? 32'h0000_0002 : 32'h0000_0001;
      `EABF_SZ_WORD: size_step = 32'h0000_0002;
      default:       size_step = 32'h0000_0004;
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Effective address generation.

  always @* begin
    is_mem   = 1'b0;
    is_pre   = 1'b0;
    pre_sum  = 32'h0000_0000;
    next_ea  = 32'h0000_0000;
    base_val = (ea_mode >= `EABF_EA_PC_DISP16 && ea_mode <= `EABF_EA_PC_MEM_PRE) ? pc_value : areg_val;
    case (ea_mode)
      `EABF_EA_DREG:       next_ea = dreg_val;
      `EABF_EA_AREG:       next_ea = areg_val;
      `EABF_EA_IND:        next_ea = areg_val;
      `EABF_EA_POSTINC:    next_ea = areg_val;
      `EABF_EA_PREDEC:     next_ea = areg_val - size_step;
      `EABF_EA_DISP16,
      `EABF_EA_PC_DISP16:  next_ea = base_val + d_short;
      `EABF_EA_IDX8,
      `EABF_EA_PC_IDX8:    next_ea = base_val + d_short + idx_scaled;
      `EABF_EA_IDXBD,
      `EABF_EA_PC_IDXBD:   next_ea = base_val + base_disp_ext + idx_scaled;
      `EABF_EA_MEM_POST,
      `EABF_EA_PC_MEM_POST: begin
        is_mem  = 1'b1;
        pre_sum = base_val + base_disp_ext;
      end
      `EABF_EA_MEM_PRE,
      `EABF_EA_PC_MEM_PRE: begin
        is_mem  = 1'b1;
        is_pre  = 1'b1;
        pre_sum = base_val + base_disp_ext + idx_scaled;
      end
      `EABF_EA_ABS_W:      next_ea = {{16{ext_word[15]}}, ext_word[15:0]};
      `EABF_EA_ABS_L:      next_ea = ext_word;
      `EABF_EA_IMM: begin
        case (op_size)
          `EABF_SZ_BYTE: next_ea = {24'h00_0000, ext_word[7:0]};
          `EABF_SZ_WORD: next_ea = {16'h0000, ext_word[15:0]};
          default:       next_ea = ext_word;
        endcase
      end
      default:             next_ea = 32'h0000_0000;
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Bit fields, BCD, bounds and quad.

  wire [31:0] fx_u;
  wire [31:0] fx_s;
  wire [5:0]  ff_pos;
  wire        f_msb;
  wire        f_zero;
  wire [63:0] f_mod;
  reg  [1:0]  mod_kind;
  reg  [5:0]  width_eff;

  always @* begin
    width_eff = (field_width[4:0] == 5'h00) ? 6'd32 : {1'b0, field_width[4:0]};
    case (op_code)
      `EABF_OP_BF_CHG: mod_kind = 2'h1;
      `EABF_OP_BF_CLR: mod_kind = 2'h2;
      `EABF_OP_BF_SET: mod_kind = 2'h3;
      default:         mod_kind = 2'h0;
    endcase
  end

  eabf_field_unit #(
    .W (W)
  ) u_field (
    .field_window    (field_window),
    .field_offset    (field_offset),
    .field_width     (width_eff),
    .insert_value    (operand_a),
    .modify_kind     (mod_kind),
    .extract_u       (fx_u),
    .extract_s       (fx_s),
    .first_one       (ff_pos),
    .field_msb       (f_msb),
    .field_zero      (f_zero),
    .modified_window (f_mod)
  );

  reg  [31:0] alu_res;
  reg  [63:0] quad_res;
  reg  [63:0] win_res;
  reg  [3:0]  cc_res;
  reg         trap_res;
  reg         below;
  reg         above;
  reg  [15:0] pack_sum;
  reg  [31:0] lo_b;
  reg  [31:0] hi_b;
  reg  [31:0] val_b;

  always @* begin
    alu_res  = 32'h0000_0000;
    quad_res = 64'h0000_0000_0000_0000;
    win_res  = field_window;
    cc_res   = 4'h0;
    trap_res = 1'b0;
    below    = 1'b0;
    above    = 1'b0;
    pack_sum = 16'h0000;
    case (op_size)
      `EABF_SZ_BYTE: begin
        lo_b  = {{24{bound_signed & operand_a[7]}}, operand_a[7:0]};
        hi_b  = {{24{bound_signed & operand_b[7]}}, operand_b[7:0]};
        val_b = {{24{bound_signed & dreg_val[7]}}, dreg_val[7:0]};
      end
      `EABF_SZ_WORD: begin
        lo_b  = {{16{bound_signed & operand_a[15]}}, operand_a[15:0]};
        hi_b  = {{16{bound_signed & operand_b[15]}}, operand_b[15:0]};
        val_b = {{16{bound_signed & dreg_val[15]}}, dreg_val[15:0]};
      end
      default: begin
        lo_b  = operand_a;
        hi_b  = operand_b;
        val_b = dreg_val;
      end
    endcase
    case (op_code)
      `EABF_OP_BF_INSERT: begin
        win_res = f_mod;
        cc_res[`EABF_CC_N] = operand_a[width_eff-1];
        cc_res[`EABF_CC_Z] = ((operand_a & ({32{1'b1}} >> (6'd32 - width_eff))) == 32'h0000_0000);
      end
      `EABF_OP_BF_EXTU,
      `EABF_OP_BF_EXTS: begin
        alu_res = (op_code == `EABF_OP_BF_EXTS) ? fx_s : fx_u;
        cc_res[`EABF_CC_N] = f_msb;
        cc_res[`EABF_CC_Z] = f_zero;
      end
      `EABF_OP_BF_FFO: begin
        alu_res = {26'h000_0000, field_offset} + {26'h000_0000, ff_pos};
        cc_res[`EABF_CC_N] = f_msb;
        cc_res[`EABF_CC_Z] = f_zero;
      end
      `EABF_OP_BF_TST,
      `EABF_OP_BF_CHG,
      `EABF_OP_BF_CLR,
      `EABF_OP_BF_SET: begin
        cc_res[`EABF_CC_N] = f_msb;
        cc_res[`EABF_CC_Z] = f_zero;
        win_res = (op_code == `EABF_OP_BF_TST) ? field_window : f_mod;
      end
      `EABF_OP_BCD_PACK: begin
        pack_sum = operand_a[15:0] + bcd_adjust;
        alu_res  = {24'h00_0000, pack_sum[11:8], pack_sum[3:0]};
      end
      `EABF_OP_BCD_EXPAND: begin
        pack_sum = {4'h0, operand_a[7:4], 4'h0, operand_a[3:0]} + bcd_adjust;
        alu_res  = {16'h0000, pack_sum};
      end
      `EABF_OP_BOUND_CMP,
      `EABF_OP_BOUND_TRAP: begin
        if (bound_signed) begin
          below = ($signed(val_b) < $signed(lo_b));
          above = ($signed(val_b) > $signed(hi_b));
        end else begin
          below = (val_b < lo_b);
          above = (val_b > hi_b);
        end
        cc_res[`EABF_CC_Z] = (val_b == lo_b) || (val_b == hi_b);
        cc_res[`EABF_CC_C] = below | above;
        trap_res = (op_code == `EABF_OP_BOUND_TRAP) && (below | above);
      end
      `EABF_OP_ADD64: begin
        quad_res = quad_a + quad_b;
        cc_res[`EABF_CC_N] = quad_res[63];
        cc_res[`EABF_CC_Z] = (quad_res == 64'h0000_0000_0000_0000);
      end
      default: alu_res = 32'h0000_0000;
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Sequencing and registered outputs.

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= S_IDLE;
      saved_post  <= `EABF_RST_WORD;
      mem_req     <= 1'b0;
      mem_addr    <= `EABF_RST_WORD;
      done        <= 1'b0;
      ea_out      <= `EABF_RST_WORD;
      ea_is_reg   <= 1'b0;
      areg_we     <= 1'b0;
      areg_new    <= `EABF_RST_WORD;
      result      <= `EABF_RST_WORD;
      result_quad <= 64'h0000_0000_0000_0000;
      window_out  <= 64'h0000_0000_0000_0000;
      ccr_out     <= 4'h0;
      trap        <= 1'b0;
    end else begin
      done    <= 1'b0;
      areg_we <= 1'b0;
      trap    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            if (op_code == `EABF_OP_EA && is_mem) begin
              mem_req    <= 1'b1;
              mem_addr   <= pre_sum;
              saved_post <= (is_pre ? 32'h0000_0000 : idx_scaled) + outer_disp_ext;
              state      <= S_FETCH;
            end else begin
              ea_out      <= next_ea;
              ea_is_reg   <= (ea_mode == `EABF_EA_DREG) || (ea_mode == `EABF_EA_AREG);
              areg_we     <= (op_code == `EABF_OP_EA) &&
                             (ea_mode == `EABF_EA_POSTINC || ea_mode == `EABF_EA_PREDEC);
              areg_new    <= (ea_mode == `EABF_EA_POSTINC) ? areg_val + size_step : next_ea;
              result      <= alu_res;
              result_quad <= quad_res;
              window_out  <= win_res;
              ccr_out     <= cc_res;
              trap        <= trap_res;
              state       <= S_DONE;
            end
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            ea_out    <= mem_rdata + saved_post;
            ea_is_reg <= 1'b0;
            state     <= S_DONE;
          end
        end
        S_DONE: begin
          done  <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: logic/eabf_field_unit.v */
// Holds the bit-field unit: shift, mask, extract, insert and scan.
// Assumes offset and width arrive already reduced to a 64-bit window.
`timescale 1ns/1ps
module eabf_field_unit #(
  parameter W = 32
) (
  input  wire [2*W-1:0] field_window,
  input  wire [5:0]     field_offset,
  input  wire [5:0]     field_width,
  input  wire [W-1:0]   insert_value,
  input  wire [1:0]     modify_kind,
  output reg  [W-1:0]   extract_u,
  output reg  [W-1:0]   extract_s,
  output reg  [5:0]     first_one,
  output reg            field_msb,
  output reg            field_zero,
  output reg  [2*W-1:0] modified_window
);

  reg [2*W-1:0] mask;
  reg [2*W-1:0] shifted;
  reg [2*W-1:0] new_bits;
  reg [W-1:0]   ones;
  reg           found;
  integer       i;

  always @* begin
    ones       = {W{1'b1}} >> (W - field_width);
    mask       = {{W{1'b0}}, ones} << (2*W - field_offset - field_width);
    shifted    = field_window >> (2*W - field_offset - field_width);
    extract_u  = shifted[W-1:0] & ones;
    field_msb  = extract_u[field_width-1];
    extract_s  = field_msb ? (extract_u | ~ones) : extract_u;
    field_zero = (extract_u == {W{1'b0}});
    first_one  = field_width;
    found      = 1'b0;
    for (i = 0; i < W; i = i + 1) begin
      if (!found && (i < field_width) && extract_u[field_width-1-i]) begin
        first_one = i[5:0];
        found     = 1'b1;
      end
    end
    new_bits   = {{W{1'b0}}, insert_value & ones} << (2*W - field_offset - field_width);
    case (modify_kind)
      2'h0: modified_window = field_window;
      2'h1: modified_window = field_window ^ mask;
      2'h2: modified_window = field_window & ~mask;
      2'h3: modified_window = field_window | mask;
      default: modified_window = field_window;
    endcase
    if (modify_kind == 2'h0) begin
      modified_window = (field_window & ~mask) | new_bits;
    end
  end

endmodule

/* File: shared/eabf_defs.vh */
// Holds the encodings and constants shared by the datapath files.
// Assumes it is included by bare name from design and bench files.
`ifndef EABF_DEFS_VH
`define EABF_DEFS_VH

// Operation codes on op_code.
`define EABF_OP_NONE        5'h00
`define EABF_OP_EA          5'h01
`define EABF_OP_BF_INSERT   5'h02
`define EABF_OP_BF_EXTU     5'h03
`define EABF_OP_BF_EXTS     5'h04
`define EABF_OP_BF_FFO      5'h05
`define EABF_OP_BF_TST      5'h06
`define EABF_OP_BF_CHG      5'h07
`define EABF_OP_BF_CLR      5'h08
`define EABF_OP_BF_SET      5'h09
`define EABF_OP_BCD_PACK    5'h0A
`define EABF_OP_BCD_EXPAND  5'h0B
`define EABF_OP_BOUND_CMP   5'h0C
`define EABF_OP_BOUND_TRAP  5'h0D
`define EABF_OP_ADD64       5'h0E

// Addressing mode codes on ea_mode (eighteen modes).
`define EABF_EA_DREG        5'h00
`define EABF_EA_AREG        5'h01
`define EABF_EA_IND         5'h02
`define EABF_EA_POSTINC     5'h03
`define EABF_EA_PREDEC      5'h04
`define EABF_EA_DISP16      5'h05
`define EABF_EA_IDX8        5'h06
`define EABF_EA_IDXBD       5'h07
`define EABF_EA_MEM_POST    5'h08
`define EABF_EA_MEM_PRE     5'h09
`define EABF_EA_PC_DISP16   5'h0A
`define EABF_EA_PC_IDX8     5'h0B
`define EABF_EA_PC_IDXBD    5'h0C
`define EABF_EA_PC_MEM_POST 5'h0D
`define EABF_EA_PC_MEM_PRE  5'h0E
`define EABF_EA_ABS_W       5'h0F
`define EABF_EA_ABS_L       5'h10
`define EABF_EA_IMM         5'h11

// Operand size codes on op_size.
`define EABF_SZ_BYTE        2'h0
`define EABF_SZ_WORD        2'h1
`define EABF_SZ_LONG        2'h2

// Condition code bit positions in ccr_out.
`define EABF_CC_C           0
`define EABF_CC_V           1
`define EABF_CC_Z           2
`define EABF_CC_N           3

// Reset value of the 32-bit word outputs.
`define EABF_RST_WORD       32'h0000_0000

`endif

/* File: sim/eabf_checker.sv */
// Holds the port checker for the datapath and its bind.
// Assumes the decoder pulses start and the memory side answers mem_req.
`timescale 1ns/1ps
`include "eabf_defs.vh"
module eabf_checker (
  input logic        clk,
  input logic        arst_n,
  input logic        start,
  input logic [4:0]  op_code,
  input logic        mem_req,
  input logic        mem_ack,
  input logic [31:0] mem_addr,
  input logic        done,
  input logic        trap,
  input logic        areg_we,
  input logic [3:0]  ccr_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////
  // Tracks when an operation is taken and which one it was.
  logic       busy;
  logic [4:0] last_op;
  wire        take = start && (!busy || done);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy    <= 1'b0;
      last_op <= 5'h00;
    end else begin
      busy    <= take ? 1'b1 : (done ? 1'b0 : busy);
      last_op <= take ? op_code : last_op;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_short_done: assert property (take && op_code != `EABF_OP_EA |=> !done ##1 done)
    else $error("done not two cycles after start");
  a_trap_done: assert property (trap |=> done && !trap)
    else $error("trap not followed by done");
  a_trap_cause: assert property (trap |-> $past(take) &&
    $past(op_code) == `EABF_OP_BOUND_TRAP && ccr_out[`EABF_CC_C])
    else $error("trap without out of range check");
  a_trap_needed: assert property (done && last_op == `EABF_OP_BOUND_TRAP |->
    $past(trap) == ccr_out[`EABF_CC_C])
    else $error("trap does not match carry");
  a_bound_flags: assert property (done &&
    (last_op == `EABF_OP_BOUND_CMP || last_op == `EABF_OP_BOUND_TRAP) |-> !ccr_out[`EABF_CC_V] && !ccr_out[`EABF_CC_N])
    else $error("bound flags V or N set");
  a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped early");
  a_fetch_end: assert property (mem_req && mem_ack |=> !mem_req ##1 done)
    else $error("fetch end not followed by done");
  a_fetch_cause: assert property ($rose(mem_req) |-> $past(take) && $past(op_code) == `EABF_OP_EA)
    else $error("fetch without address start");
  a_areg_pulse: assert property (areg_we |=> done && !areg_we)
    else $error("register update not one cycle");
endmodule
bind eabf_datapath eabf_checker chk_i (.clk(clk), .arst_n(arst_n), .start(start), .op_code(op_code),
  .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr), .done(done), .trap(trap),
  .areg_we(areg_we), .ccr_out(ccr_out));

/* File: sim/eabf_mem_model.sv */
// Holds the memory side model answering long word fetches.
// Assumes mem_req stays high until mem_ack is sampled.
`timescale 1ns/1ps
module eabf_mem_model (
  input  logic        clk,
  input  logic        arst_n,
  input  logic        mem_req,
  input  logic [31:0] mem_addr,
  input  logic [3:0]  mem_delay,
  output logic        mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      cnt       <= 4'h0;
    end else if (mem_req && !mem_ack && cnt == mem_delay) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_addr ^ 32'h00A5_0000;
      cnt       <= 4'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt       <= (mem_req && !mem_ack) ? cnt + 4'h1 : cnt;
    end
  end
endmodule

/* File: sim/testbench.sv */
// Holds the self-checking bench of the datapath.
// Assumes the memory model answers with address xor a fixed pattern.
`timescale 1ns/1ps
`include "eabf_defs.vh"
module testbench;
  localparam [31:0] K = 32'h00A5_0000, A2 = 32'h0000_1000, A7 = 32'h0000_2000;
  localparam [31:0] PC = 32'h0004_0000, BASE_D = 32'h0010_0000, OUTER_D = 32'h0001_0010;
  logic         clk, arst_n, start, index_long, index_suppress, short_disp_is8;
  logic         base_disp_long, outer_disp_long, bound_signed, mem_ack, trp, awe;
  logic [5:0]   field_offset, field_width;
  logic [4:0]   op_code, ea_mode;
  logic [1:0]   op_size, index_scale;
  logic [2:0]   data_reg_select, addr_reg_select;
  logic [3:0]   index_reg_select, mem_delay, ccr_out;
  logic [15:0]  short_disp, bcd_adjust;
  logic [31:0]  base_displacement, outer_displacement, ext_word, pc_value, operand_a, operand_b;
  logic [31:0]  mem_rdata, mem_addr, ea_out, areg_new, result;
  logic [63:0]  field_window, quad_a, quad_b, result_quad, window_out;
  logic [255:0] data_regs, addr_regs;
  logic         mem_req, done, ea_is_reg, areg_we, trap;
  int           bad_count, checked, cyc;
  eabf_datapath DUT (.*);
  eabf_mem_model mem (.*);
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      results;
    end
  end
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input [63:0] e, input [63:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task go(input [4:0] op);
    int n;
    @(negedge clk);
    op_code = op;
    start = 1;
    @(negedge clk);
    start = 0;
    {trp, awe} = 2'b00;
    for (n = 0; n < 40 && done !== 1'b1; n++) begin
      if (trap === 1'b1) trp = 1;
      if (areg_we === 1'b1) awe = 1;
      @(negedge clk);
    end
    chk("done", 1, done);
  endtask
  function automatic [31:0] idx(input [3:0] s, input l, input [1:0] sc);
    logic [31:0] r;
    r = s[3] ? addr_regs[s[2:0]*32+:32] : data_regs[s[2:0]*32+:32];
    if (!l) r = {{16{r[15]}}, r[15:0]};
    return r << sc;
  endfunction
  ////////////////////////////////////////////////////////////////
  task ea(input [4:0] m, input [31:0] e);
    ea_mode = m;
    go(`EABF_OP_EA);
    chk("ea_out", e, ea_out);
  endtask
  task test_ea;
    addr_regs[2*32+:32] = A2;
    addr_regs[7*32+:32] = A7;
    data_regs[3*32+:32] = 32'h0000_FFFE;
    {addr_reg_select, index_reg_select, index_scale, op_size} = {3'd2, 4'd3, 2'd2, `EABF_SZ_LONG};
    {short_disp, pc_value, ext_word, base_displacement} = {16'hFFF0, PC, 32'h1234_5678, 32'h0000_8000};
    {outer_displacement, outer_disp_long} = {OUTER_D, 1'b1};
    ea(`EABF_EA_IND, A2);
    chk("areg_we", 0, awe);
    ea(`EABF_EA_DISP16, A2 - 16);
    short_disp = 16'h0080;
    short_disp_is8 = 1;
    ea(`EABF_EA_IDX8, A2 - 128 + idx(3, 0, 2));
    ea(`EABF_EA_PC_IDX8, PC - 128 + idx(3, 0, 2));
    ea(`EABF_EA_IDXBD, A2 - 32'h8000 + idx(3, 0, 2));
    {base_displacement, base_disp_long} = {BASE_D, 1'b1};
    ea(`EABF_EA_MEM_POST, ((A2 + BASE_D) ^ K) + idx(3, 0, 2) + OUTER_D);
    mem_delay = 3;
    ea(`EABF_EA_MEM_PRE, ((A2 + BASE_D + idx(3, 0, 2)) ^ K) + OUTER_D);
    {index_reg_select, index_long, index_scale} = {4'hA, 1'b1, 2'd3};
    ea(`EABF_EA_PC_IDXBD, PC + BASE_D + idx(4'hA, 1, 3));
    outer_disp_long = 0;
    ea(`EABF_EA_PC_MEM_POST, ((PC + BASE_D) ^ K) + idx(4'hA, 1, 3) + 32'h10);
    index_suppress = 1;
    ea(`EABF_EA_PC_MEM_PRE, ((PC + BASE_D) ^ K) + 32'h10);
    short_disp_is8 = 0;
    ea(`EABF_EA_PC_DISP16, PC + 128);
    ea(`EABF_EA_ABS_L, 32'h1234_5678);
    ea(`EABF_EA_ABS_W, 32'h0000_5678);
    data_reg_select = 3'd3;
    ea(`EABF_EA_DREG, 32'h0000_FFFE);
    chk("ea_is_reg", 1, ea_is_reg);
    ea(`EABF_EA_PREDEC, A2 - 4);
    chk("areg_new", A2 - 4, areg_new);
    chk("areg_we", 1, awe);
    {addr_reg_select, op_size} = {3'd7, `EABF_SZ_BYTE};
    ea(`EABF_EA_POSTINC, A7);
    chk("areg_new", A7 + 2, areg_new);
    ea(`EABF_EA_AREG, A7);
    ea(`EABF_EA_IMM, 32'h0000_0078);
    $display("test address generation done");
  endtask
  ////////////////////////////////////////////////////////////////
  task fc(input [5:0] off, input [5:0] wc);
    int w, p, i;
    logic [63:0] f, m, s;
    w = (wc == 0) ? 32 : wc;
    f = (field_window << off) >> (64 - w);
    m = (~64'h0 << (64 - w)) >> off;
    s = f[w-1] ? (f | (~64'h0 << w)) : f;
    p = w;
    for (i = w - 1; i >= 0; i--) if (f[i] && p == w) p = w - 1 - i;
    {field_offset, field_width} = {off, wc};
    go(`EABF_OP_BF_EXTU);
    chk("extract_u", f, result);
    go(`EABF_OP_BF_EXTS);
    chk("extract_s", s[31:0], result);
    go(`EABF_OP_BF_FFO);
    chk("first_one", off + p, result);
    go(`EABF_OP_BF_TST);
    chk("tst_ccr", {f[w-1], f == 0}, ccr_out[3:2]);
    go(`EABF_OP_BF_SET);
    chk("set_window", field_window | m, window_out);
    go(`EABF_OP_BF_CLR);
    chk("clr_window", field_window & ~m, window_out);
    go(`EABF_OP_BF_CHG);
    chk("chg_window", field_window ^ m, window_out);
    chk("chg_ccr", {f[w-1], f == 0}, ccr_out[3:2]);
    go(`EABF_OP_BF_INSERT);
    chk("insert", (field_window & ~m) | (({32'h0, operand_a} << (64 - w)) >> off), window_out);
  endtask
  task test_field;
    field_window = 64'h0123_4567_89AB_CDEF;
    operand_a = 32'hFFFF_FFA5;
    fc(6'd28, 6'd8);
    fc(6'd32, 6'd0);
    fc(6'd5, 6'd3);
    fc(6'd0, 6'd4);
    fc(6'd31, 6'd1);
    $display("test bit fields done");
  endtask
  ////////////////////////////////////////////////////////////////
  task test_bcd;
    {operand_a, bcd_adjust} = {32'h0000_3739, 16'h0000};
    go(`EABF_OP_BCD_PACK);
    chk("pack", 32'h79, result);
    {operand_a, bcd_adjust} = {32'h0000_0204, 16'h0101};
    go(`EABF_OP_BCD_PACK);
    chk("pack", 32'h35, result);
    {operand_a, bcd_adjust} = {32'h0000_0079, 16'h3030};
    go(`EABF_OP_BCD_EXPAND);
    chk("expand", 32'h3739, result);
    {quad_a, quad_b} = {64'h0000_0001_FFFF_FFFF, 64'h1};
    go(`EABF_OP_ADD64);
    chk("quad", 64'h0000_0002_0000_0000, result_quad);
    $display("test bcd and quad done");
  endtask
  task bnd(input s, input [1:0] sz, input [31:0] v, input [31:0] lo, input [31:0] hi, input c, input z);
    {bound_signed, op_size, data_reg_select, operand_a, operand_b} = {s, sz, 3'd5, lo, hi};
    data_regs[5*32+:32] = v;
    go(`EABF_OP_BOUND_CMP);
    chk("bound_cmp_ccr", {1'b0, z, 1'b0, c}, ccr_out);
    chk("bound_cmp_trap", 0, trp);
    go(`EABF_OP_BOUND_TRAP);
    chk("bound_trap_ccr", {1'b0, z, 1'b0, c}, ccr_out);
    chk("bound_trap_trap", c, trp);
  endtask
  task test_bounds;
    bnd(0, `EABF_SZ_LONG, 9, 10, 20, 1, 0);
    bnd(0, `EABF_SZ_LONG, 10, 10, 20, 0, 1);
    bnd(0, `EABF_SZ_LONG, 20, 10, 20, 0, 1);
    bnd(0, `EABF_SZ_LONG, 21, 10, 20, 1, 0);
    bnd(1, `EABF_SZ_LONG, 32'hFFFF_FFFA, 32'hFFFF_FFFB, 5, 1, 0);
    bnd(1, `EABF_SZ_LONG, 32'hFFFF_FFF0, 32'hFFFF_FF00, 16, 0, 0);
    bnd(1, `EABF_SZ_BYTE, 32'h1234_5680, 32'h80, 32'h7F, 0, 1);
    bnd(0, `EABF_SZ_WORD, 32'hFFFF_0005, 1, 4, 1, 0);
    $display("test bounds done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {bad_count, checked, cyc, arst_n, trp, mem_delay} = '0;
    {start, op_code, ea_mode, op_size, data_reg_select, addr_reg_select, index_reg_select} = '0;
    {index_long, index_scale, index_suppress, short_disp, short_disp_is8, bound_signed} = '0;
    {base_displacement, base_disp_long, outer_displacement, outer_disp_long, ext_word} = '0;
    {pc_value, data_regs, addr_regs, field_window, field_offset, field_width} = '0;
    {operand_a, operand_b, quad_a, quad_b, bcd_adjust} = '0;
    repeat (8) @(negedge clk);
    arst_n = 1;
    test_ea;
    test_field;
    test_bcd;
    test_bounds;
    results;
  end
endmodule
